// file: include/sdrt_defines.svh
`ifndef SDRT_DEFINES_SVH
`define SDRT_DEFINES_SVH

// ==========================================================
// clock and speed grades
`define SDRT_CLK_NS 100
`define SDRT_FMAX_FAST_MHZ 166
`define SDRT_FMAX_SLOW_MHZ 143

// ==========================================================
// command spacing in cycles
`define SDRT_CL_CYC 3
`define SDRT_RCD_CYC 3
`define SDRT_RC_CYC 10
`define SDRT_RAS_CYC 7
`define SDRT_RAS_MAX_NS 100000
`define SDRT_RAS_MAX_CYC (`SDRT_RAS_MAX_NS / `SDRT_CLK_NS)
`define SDRT_RP_CYC 3
`define SDRT_RRD_CYC 2
`define SDRT_DPL_CYC 2
`define SDRT_DAL_CYC 5
`define SDRT_PQL_CYC 2
`define SDRT_MRD_CYC 2
`define SDRT_DDE_NS 7
`define SDRT_DDE_CYC ((`SDRT_DDE_NS + `SDRT_CLK_NS - 1) / `SDRT_CLK_NS)

// ==========================================================
// refresh and power-up
`define SDRT_REF_MS 64
`define SDRT_REF_ROWS 4096
`define SDRT_REFI_CYC ((`SDRT_REF_MS * 1000000 / `SDRT_CLK_NS) / `SDRT_REF_ROWS)
`define SDRT_POWERUP_CYC 100

// ==========================================================
// mode words and address fields
`define SDRT_MODE_VALUE 12'h030
`define SDRT_EXT_MODE_VALUE 12'h000
`define SDRT_BA_MODE 2'h0
`define SDRT_BA_EXT_MODE 2'h2
`define SDRT_AP_BIT 10

`endif

// file: include/sdrt_pkg.sv
package sdrt_pkg;

    // ==========================================================
    // command codes {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        SDRT_CMD_MRS = 4'h0,
        SDRT_CMD_REF = 4'h1,
        SDRT_CMD_PRE = 4'h2,
        SDRT_CMD_ACT = 4'h3,
        SDRT_CMD_WR = 4'h4,
        SDRT_CMD_RD = 4'h5,
        SDRT_CMD_BST = 4'h6,
        SDRT_CMD_NOP = 4'h7
    } sdrt_cmd_type;

    // ==========================================================
    // controller states
    typedef enum logic [10:0] {
        ST_PWRUP = 11'h001,
        ST_PREALL = 11'h002,
        ST_INITREF = 11'h004,
        ST_MRS = 11'h008,
        ST_EMRS = 11'h010,
        ST_IDLE = 11'h020,
        ST_ACT = 11'h040,
        ST_COL = 11'h080,
        ST_PDN = 11'h100,
        ST_PDX = 11'h200,
        ST_SPARE = 11'h400
    } sdrt_state_type;

    typedef struct packed {
        logic [3:0] cnt;
    } sdrt_timer_type;

    typedef struct packed {
        sdrt_state_type state;
        logic [7:0] wait_cnt;
        logic [7:0] refi_cnt;
        logic ref_due;
        logic init_ref_done;
        logic init_done;
        logic ready;
        logic cke;
        sdrt_cmd_type cmd;
        logic [1:0] ba;
        logic [11:0] addr;
        logic [1:0] dqm;
        logic [15:0] dq;
        logic dq_oe;
        logic [3:0] rd_pipe;
        logic [1:0] rd_mask;
        logic rsp_valid;
        logic [15:0] rsp_data;
        logic req_wr;
        logic [1:0] req_ba;
        logic [11:0] req_row;
        logic [11:0] req_col;
        logic [15:0] req_wdata;
        logic [1:0] req_mask;
    } sdrt_ctl_type;

    typedef struct packed {
        logic [11:0] mode;
        logic [11:0] ext_mode;
        logic [3:0] opened;
        logic [3:0][1:0] row;
        logic bact;
        logic bwr;
        logic bap;
        logic [1:0] bbank;
        logic [3:0] bcol;
        logic [3:0] bleft;
        logic ap_close;
        logic [1:0] ap_bank;
        logic s1_v;
        logic [15:0] s1_d;
        logic [1:0] s2_v;
        logic [15:0] s2_d;
        logic [1:0] out_v;
        logic [15:0] out_d;
        logic pdn;
    } sdrt_mem_type;

endpackage

// file: include/sdrt_link_if.sv
`timescale 1ns/1ns
interface sdrt_link_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [1:0] dqm;
    logic [15:0] ctl_dq;
    logic ctl_dq_oe;
    logic [15:0] dev_dq;
    logic [1:0] dev_dq_oe;

    modport ctl (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe,
        input dev_dq, dev_dq_oe
    );

    modport mem (
        input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe,
        output dev_dq, dev_dq_oe
    );
endinterface

// file: rtl/sdrt_hold_timer.sv
`timescale 1ns/1ns
module sdrt_hold_timer
    import sdrt_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [3:0] len,
    output logic busy
);
    sdrt_timer_type tm_q;
    sdrt_timer_type tm_d;

    // ==========================================================
    // countdown, a load only ever lengthens the hold
    always_comb begin
        tm_d.cnt = (tm_q.cnt != 4'h0) ? tm_q.cnt - 4'h1 : 4'h0;
        if (load && ((len - 4'h1) > tm_d.cnt)) begin
            tm_d.cnt = len - 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tm_q <= '0;
        end else begin
            tm_q <= tm_d;
        end
    end

    assign busy = (tm_q.cnt != 4'h0);
endmodule

// file: rtl/sdrt_mem_end.sv
`timescale 1ns/1ns
`include "sdrt_defines.svh"
module sdrt_mem_end
    import sdrt_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    sdrt_link_if.mem link,
    output logic [3:0] bank_open,
    output logic power_down
);
    logic [15:0] mem [0:255];
    sdrt_mem_type m_q;
    sdrt_mem_type m_d;
    sdrt_cmd_type cmd;
    logic cur_act;
    logic cur_wr;
    logic cur_ap;
    logic [1:0] cur_bank;
    logic [3:0] cur_col;
    logic [3:0] cur_left;
    logic [3:0] blen;
    logic wr_en;
    logic [1:0] wr_lane;
    logic [7:0] mem_idx;

    // ==========================================================
    // command decode and burst engine
    always_comb begin
        m_d = m_q;
        cmd = link.cke ? sdrt_cmd_type'({link.cs_n, link.ras_n, link.cas_n, link.we_n}) : SDRT_CMD_NOP;
        case (m_q.mode[2:0])
            3'h0: blen = 4'h1;
            3'h1: blen = 4'h2;
            3'h2: blen = 4'h4;
            default: blen = 4'h8;
        endcase
        m_d.pdn = !link.cke;
        m_d.s2_v = {2{m_q.s1_v}} & ~link.dqm;
        m_d.s2_d = m_q.s1_d;
        m_d.out_v = m_q.s2_v;
        m_d.out_d = m_q.s2_d;
        m_d.s1_v = 1'b0;
        m_d.ap_close = 1'b0;
        if (m_q.ap_close) begin
            m_d.opened[m_q.ap_bank] = 1'b0;
        end
        cur_act = m_q.bact;
        cur_wr = m_q.bwr;
        cur_ap = m_q.bap;
        cur_bank = m_q.bbank;
        cur_col = m_q.bcol;
        cur_left = m_q.bleft;
        case (cmd)
            SDRT_CMD_ACT: begin
                m_d.opened[link.ba] = 1'b1;
                m_d.row[link.ba] = link.addr[1:0];
            end
            SDRT_CMD_RD, SDRT_CMD_WR: begin
                if (m_q.opened[link.ba]) begin
                    cur_act = 1'b1;
                    cur_wr = (cmd == SDRT_CMD_WR);
                    cur_bank = link.ba;
                    cur_col = link.addr[3:0];
                    cur_left = blen;
                    cur_ap = link.addr[`SDRT_AP_BIT];
                end
            end
            SDRT_CMD_BST: begin
                cur_act = 1'b0;
            end
            SDRT_CMD_PRE: begin
                if (link.addr[`SDRT_AP_BIT]) begin
                    m_d.opened = 4'h0;
                end else begin
                    m_d.opened[link.ba] = 1'b0;
                end
                if (link.addr[`SDRT_AP_BIT] || (link.ba == cur_bank)) begin
                    cur_act = 1'b0;
                end
            end
            SDRT_CMD_MRS: begin
                if (link.ba == `SDRT_BA_MODE) begin
                    m_d.mode = link.addr;
                end else if (link.ba == `SDRT_BA_EXT_MODE) begin
                    m_d.ext_mode = link.addr;
                end
            end
            default: begin
            end
        endcase
        mem_idx = {cur_bank, m_q.row[cur_bank], cur_col};
        wr_en = cur_act && cur_wr;
        wr_lane = ~link.dqm;
        if (cur_act && !cur_wr) begin
            m_d.s1_v = 1'b1;
            m_d.s1_d = mem[mem_idx];
        end
        m_d.bact = cur_act && (cur_left != 4'h1);
        m_d.bwr = cur_wr;
        m_d.bap = cur_ap;
        m_d.bbank = cur_bank;
        m_d.bcol = cur_col + 4'h1;
        m_d.bleft = cur_left - 4'h1;
        if (cur_act && (cur_left == 4'h1) && cur_ap) begin
            m_d.ap_close = 1'b1;
            m_d.ap_bank = cur_bank;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            m_q <= '0;
        end else begin
            m_q <= m_d;
        end
    end

    // ==========================================================
    // byte-lane array writes
    always_ff @(posedge clock) begin
        if (wr_en && wr_lane[0]) begin
            mem[mem_idx][7:0] <= link.ctl_dq[7:0];
        end
        if (wr_en && wr_lane[1]) begin
            mem[mem_idx][15:8] <= link.ctl_dq[15:8];
        end
    end

    assign link.dev_dq = m_q.out_d;
    assign link.dev_dq_oe = m_q.out_v;
    assign bank_open = m_q.opened;
    assign power_down = m_q.pdn;
endmodule

// file: rtl/sdrt_ctl_end.sv
// Summary of operation
// - finish power-on sequence before normal accesses
// - CAS latency three, clock within grade limit
// - activate to column at least three cycles
// - activate-activate or refresh-refresh ten cycles
// - row open seven cycles, under 100K ns
// - precharge to activate at least three cycles
// - activates to different banks two cycles apart
// - column commands may follow every cycle
// - last write data to precharge two cycles
// - write autoprecharge data to activate five cycles
// - burst stop floats read data after three
// - burst stop ignores write data immediately
// - precharge floats read data after three cycles
// - precharge ignores write data immediately
// - read autoprecharge starts two before last data
// - read byte mask acts two cycles later
// - write byte mask acts same cycle
// - mode register set then one idle cycle
// - 4096 refreshes within every 64 ms
// - wait after clock enable rises before command
// - extended mode set with bank bits 10
`timescale 1ns/1ns
`include "sdrt_defines.svh"
module sdrt_ctl_end
    import sdrt_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_bank,
    input wire logic [11:0] req_row,
    input wire logic [11:0] req_col,
    input wire logic [15:0] req_wdata,
    input wire logic [1:0] req_mask,
    input wire logic sleep_req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic init_done,
    sdrt_link_if.ctl link
);
    sdrt_ctl_type st_q;
    sdrt_ctl_type st_d;
    logic [3:0] bank_busy;
    logic [3:0] bank_load;
    logic [3:0] bank_len;
    logic rrd_busy;
    logic rrd_load;
    logic [3:0] col_wait;

    // ==========================================================
    // per-bank activate holds and the bank-to-bank hold
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_bank
            sdrt_hold_timer u_bank (
                .clock(clock),
                .sys_rst(sys_rst),
                .load(bank_load[gi]),
                .len(bank_len),
                .busy(bank_busy[gi])
            );
        end
    endgenerate

    sdrt_hold_timer u_rrd (
        .clock(clock),
        .sys_rst(sys_rst),
        .load(rrd_load),
        .len(4'(`SDRT_RRD_CYC)),
        .busy(rrd_busy)
    );

    // ==========================================================
    // command sequencer
    always_comb begin
        st_d = st_q;
        st_d.cmd = SDRT_CMD_NOP;
        st_d.dqm = 2'h0;
        st_d.dq_oe = 1'b0;
        st_d.rsp_valid = 1'b0;
        st_d.rd_pipe = {st_q.rd_pipe[`SDRT_CL_CYC-1:0], 1'b0};
        bank_load = 4'h0;
        bank_len = 4'h0;
        rrd_load = 1'b0;
        col_wait = 4'h0;
        if (st_q.wait_cnt != 8'h0) begin
            st_d.wait_cnt = st_q.wait_cnt - 8'h1;
        end
        if (st_q.rd_pipe[0]) begin
            st_d.dqm = st_q.rd_mask;
        end
        if (st_q.rd_pipe[`SDRT_CL_CYC]) begin
            st_d.rsp_valid = 1'b1;
            st_d.rsp_data = link.dev_dq;
        end
        case (st_q.state)
            ST_PWRUP: begin
                if (st_q.wait_cnt == 8'h0) begin
                    st_d.cmd = SDRT_CMD_PRE;
                    st_d.addr = 12'h000;
                    st_d.addr[`SDRT_AP_BIT] = 1'b1;
                    st_d.wait_cnt = 8'(`SDRT_RP_CYC - 1);
                    st_d.state = ST_PREALL;
                end
            end
            ST_PREALL: begin
                if (st_q.wait_cnt == 8'h0) begin
                    st_d.cmd = SDRT_CMD_REF;
                    st_d.wait_cnt = 8'(`SDRT_RC_CYC - 1);
                    st_d.state = ST_INITREF;
                end
            end
            ST_INITREF: begin
                if (st_q.wait_cnt == 8'h0) begin
                    if (!st_q.init_ref_done) begin
                        st_d.cmd = SDRT_CMD_REF;
                        st_d.wait_cnt = 8'(`SDRT_RC_CYC - 1);
                        st_d.init_ref_done = 1'b1;
                    end else begin
                        st_d.cmd = SDRT_CMD_MRS;
                        st_d.ba = `SDRT_BA_MODE;
                        st_d.addr = `SDRT_MODE_VALUE;
                        st_d.wait_cnt = 8'(`SDRT_MRD_CYC - 1);
                        st_d.state = ST_MRS;
                    end
                end
            end
            ST_MRS: begin
                if (st_q.wait_cnt == 8'h0) begin
                    st_d.cmd = SDRT_CMD_MRS;
                    st_d.ba = `SDRT_BA_EXT_MODE;
                    st_d.addr = `SDRT_EXT_MODE_VALUE;
                    st_d.wait_cnt = 8'(`SDRT_MRD_CYC - 1);
                    st_d.state = ST_EMRS;
                end
            end
            ST_EMRS: begin
                if (st_q.wait_cnt == 8'h0) begin
                    st_d.init_done = 1'b1;
                    st_d.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (st_q.ref_due) begin
                    if (bank_busy == 4'h0) begin
                        st_d.cmd = SDRT_CMD_REF;
                        bank_load = 4'hF;
                        bank_len = 4'(`SDRT_RC_CYC);
                        st_d.ref_due = 1'b0;
                    end
                end else if (req_valid && st_q.ready) begin
                    st_d.req_wr = req_write;
                    st_d.req_ba = req_bank;
                    st_d.req_row = req_row;
                    st_d.req_col = req_col;
                    st_d.req_wdata = req_wdata;
                    st_d.req_mask = req_mask;
                    st_d.state = ST_ACT;
                end else if (sleep_req) begin
                    st_d.cke = 1'b0;
                    st_d.state = ST_PDN;
                end
            end
            ST_ACT: begin
                if (!bank_busy[st_q.req_ba] && !rrd_busy) begin
                    st_d.cmd = SDRT_CMD_ACT;
                    st_d.ba = st_q.req_ba;
                    st_d.addr = st_q.req_row;
                    bank_load[st_q.req_ba] = 1'b1;
                    bank_len = 4'(`SDRT_RC_CYC);
                    rrd_load = 1'b1;
                    if (st_q.req_wr) begin
                        col_wait = 4'(`SDRT_RAS_CYC - `SDRT_DPL_CYC);
                    end else begin
                        col_wait = 4'(`SDRT_RAS_CYC - (`SDRT_CL_CYC - `SDRT_PQL_CYC));
                    end
                    if (col_wait < 4'(`SDRT_RCD_CYC)) begin
                        col_wait = 4'(`SDRT_RCD_CYC);
                    end
                    st_d.wait_cnt = 8'(col_wait - 4'h1);
                    st_d.state = ST_COL;
                end
            end
            ST_COL: begin
                if (st_q.wait_cnt == 8'h0) begin
                    st_d.ba = st_q.req_ba;
                    st_d.addr = st_q.req_col;
                    st_d.addr[`SDRT_AP_BIT] = 1'b1;
                    bank_load[st_q.req_ba] = 1'b1;
                    if (st_q.req_wr) begin
                        st_d.cmd = SDRT_CMD_WR;
                        st_d.dq = st_q.req_wdata;
                        st_d.dq_oe = 1'b1;
                        st_d.dqm = st_q.req_mask;
                        bank_len = 4'(`SDRT_DAL_CYC);
                    end else begin
                        st_d.cmd = SDRT_CMD_RD;
                        st_d.rd_pipe[0] = 1'b1;
                        st_d.rd_mask = st_q.req_mask;
                        bank_len = 4'(`SDRT_CL_CYC - `SDRT_PQL_CYC + `SDRT_RP_CYC);
                    end
                    st_d.state = ST_IDLE;
                end
            end
            ST_PDN: begin
                if (!sleep_req || st_q.ref_due) begin
                    st_d.cke = 1'b1;
                    st_d.wait_cnt = 8'(`SDRT_DDE_CYC - 1);
                    st_d.state = ST_PDX;
                end
            end
            ST_PDX: begin
                if (st_q.wait_cnt == 8'h0) begin
                    st_d.state = ST_IDLE;
                end
            end
            default: begin
                st_d.state = ST_PWRUP;
            end
        endcase
        // refresh interval, a new demand beats the clear above
        if (st_q.refi_cnt == 8'h0) begin
            st_d.refi_cnt = 8'(`SDRT_REFI_CYC - 1);
            st_d.ref_due = 1'b1;
        end else begin
            st_d.refi_cnt = st_q.refi_cnt - 8'h1;
        end
        st_d.ready = (st_d.state == ST_IDLE) && !st_d.ref_due;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.state <= ST_PWRUP;
            st_q.cmd <= SDRT_CMD_NOP;
            st_q.cke <= 1'b1;
            st_q.wait_cnt <= 8'(`SDRT_POWERUP_CYC - 1);
            st_q.refi_cnt <= 8'(`SDRT_REFI_CYC - 1);
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // registered pins and user outputs
    assign link.cke = st_q.cke;
    assign link.cs_n = st_q.cmd[3];
    assign link.ras_n = st_q.cmd[2];
    assign link.cas_n = st_q.cmd[1];
    assign link.we_n = st_q.cmd[0];
    assign link.ba = st_q.ba;
    assign link.addr = st_q.addr;
    assign link.dqm = st_q.dqm;
    assign link.ctl_dq = st_q.dq;
    assign link.ctl_dq_oe = st_q.dq_oe;
    assign req_ready = st_q.ready;
    assign rsp_valid = st_q.rsp_valid;
    assign rsp_rdata = st_q.rsp_data;
    assign init_done = st_q.init_done;
endmodule

// file: dv/sdrt_link_monitor.sv
`timescale 1ns/1ns
// ==========================================================
// link timing checks
module sdrt_link_monitor
    import sdrt_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [11:0] addr,
    input wire logic [1:0] dqm,
    input wire logic [1:0] dev_dq_oe
);
    logic [3:0] cmd;
    logic act, rd, wr, pre, rf, mrs;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign act = cke && cmd == SDRT_CMD_ACT;
    assign rd = cke && cmd == SDRT_CMD_RD;
    assign wr = cke && cmd == SDRT_CMD_WR;
    assign pre = cke && cmd == SDRT_CMD_PRE;
    assign rf = cke && cmd == SDRT_CMD_REF;
    assign mrs = cke && cmd == SDRT_CMD_MRS;

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // read data path
    sequence read_cmd_s;
        rd ##1 (dqm == 2'h0 && dev_dq_oe == 2'h0);
    endsequence
    sequence read_beat_s;
        dev_dq_oe == 2'h0 ##1 dev_dq_oe == 2'h3 ##1 dev_dq_oe == 2'h0;
    endsequence
    read_latency_a: assert property (read_cmd_s |=> read_beat_s)
        else $error("read data not on third cycle");
    read_mask_a: assert property (rd ##1 1'b1 |-> ##2 dev_dq_oe == ~$past(dqm, 2))
        else $error("read mask latency wrong");

    // ==========================================================
    // command spacing
    act_col_a: assert property (act |=> (!(rd || wr))[*2])
        else $error("column command too soon after activate");
    act_act_a: assert property (act |=> !act)
        else $error("activates too close");
    ref_gap_a: assert property (rf |=> (!(rf || act))[*8] ##1 !(rf || act))
        else $error("refresh spacing too short");
    act_pre_a: assert property (act |=> (!pre)[*6])
        else $error("row closed too early");
    pre_act_a: assert property (pre |=> (!act)[*2])
        else $error("activate too soon after precharge");
    wr_pre_a: assert property (wr |=> !pre)
        else $error("precharge too soon after write");
    wr_ap_a: assert property (wr && addr[10] |=> (!(act || rf))[*4])
        else $error("activate too soon after write autoprecharge");
    mrs_gap_a: assert property (mrs |=> cs_n || cmd == SDRT_CMD_NOP)
        else $error("command too soon after mode set");
    cke_rise_a: assert property ($rose(cke) |-> cs_n || cmd == SDRT_CMD_NOP)
        else $error("command on clock enable rise");
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench
    import sdrt_pkg::*;
;
    typedef struct packed {
        logic w; logic [1:0] b; logic [11:0] r; logic [11:0] c; logic [15:0] d; logic [1:0] m; logic [15:0] e;
    } sdrt_row_type;
    logic clock = 0;
    logic sys_rst = 1;
    logic req_valid = 0, req_write = 0, sleep_req = 0;
    logic [1:0] req_bank = '0, req_mask = '0;
    logic [11:0] req_row = '0, req_col = '0;
    logic [15:0] req_wdata = '0, rsp_rdata, rd;
    logic req_ready, rsp_valid, init_done, power_down;
    logic [3:0] bank_open, cmd;
    int fails = 0, compares = 0, early = 0, ext_seen = 0, cyc = 0, last_ref = 0, ref_gap = 0;
    sdrt_row_type rows [12] = '{
        '{1'b1, 2'h0, 12'h001, 12'h002, 16'hA5A5, 2'h0, 16'h0000},
        '{1'b1, 2'h1, 12'h002, 12'h00F, 16'h1234, 2'h0, 16'h0000},
        '{1'b1, 2'h2, 12'h003, 12'h000, 16'hFFFF, 2'h0, 16'h0000},
        '{1'b1, 2'h2, 12'h003, 12'h000, 16'h0077, 2'h1, 16'h0000},
        '{1'b1, 2'h3, 12'h000, 12'h007, 16'hBEEF, 2'h0, 16'h0000},
        '{1'b1, 2'h0, 12'h001, 12'h40A, 16'h5A5A, 2'h0, 16'h0000},
        '{1'b0, 2'h0, 12'h001, 12'h002, 16'h0000, 2'h0, 16'hA5A5},
        '{1'b0, 2'h1, 12'h002, 12'h00F, 16'h0000, 2'h0, 16'h1234},
        '{1'b0, 2'h2, 12'h003, 12'h000, 16'h0000, 2'h0, 16'h00FF},
        '{1'b0, 2'h3, 12'h000, 12'h007, 16'h0000, 2'h2, 16'hBEEF},
        '{1'b0, 2'h3, 12'h000, 12'h007, 16'h0000, 2'h0, 16'hBEEF},
        '{1'b0, 2'h0, 12'h001, 12'h00A, 16'h0000, 2'h0, 16'h5A5A}
    };

    sdrt_link_if link();
    sdrt_ctl_end sdrt_ctl_end_i (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
        .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata), .req_mask(req_mask),
        .sleep_req(sleep_req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .init_done(init_done), .link(link.ctl));
    sdrt_mem_end sdrt_mem_end_i (.clock(clock), .sys_rst(sys_rst), .link(link.mem), .bank_open(bank_open),
        .power_down(power_down));
    sdrt_link_monitor sdrt_link_monitor_i (.clock(clock), .sys_rst(sys_rst), .cke(link.cke), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .addr(link.addr),
        .dqm(link.dqm), .dev_dq_oe(link.dev_dq_oe));

    // ==========================================================
    // clock and link watch
    always #50 clock = ~clock;
    assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    always @(posedge clock) begin
        cyc++;
        if (!sys_rst && link.cke === 1'b1) begin
            if (!init_done && (cmd == 4'h3 || cmd == 4'h4 || cmd == 4'h5)) early++;
            if (cmd == 4'h0 && link.ba == 2'h2) ext_seen = 1;
            if (cmd == 4'h1) begin
                ref_gap = cyc - last_ref;
                last_ref = cyc;
            end
        end
    end

    // ==========================================================
    // tasks
    function automatic logic [15:0] keep(input logic [1:0] m);
        return {{8{~m[1]}}, {8{~m[0]}}};
    endfunction

    task stop_test;
        $display("TB: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task do_reset;
        int n;
        sys_rst = 1;
        repeat (3) @(posedge clock);
        #10 sys_rst = 0;
        `CHK(init_done, 1'b0)
        `CHK(req_ready, 1'b0)
        `CHK(link.dev_dq_oe, 2'h0)
        `CHK(bank_open, 4'h0)
        early = 0;
        ext_seen = 0;
        n = 0;
        while (init_done !== 1'b1 && n < 300) begin
            @(posedge clock);
            #10 n++;
        end
        `CHK(init_done, 1'b1)
        `CHK(early, 0)
        `CHK(ext_seen, 1)
        $display("TB: reset test done");
    endtask

    task do_req(input logic w, input logic [1:0] b, input logic [11:0] r, c, input logic [15:0] d,
        input logic [1:0] m);
        int n;
        req_valid = 1;
        req_write = w;
        req_bank = b;
        req_row = r;
        req_col = c;
        req_wdata = d;
        req_mask = m;
        n = 0;
        while (req_ready !== 1'b1 && n < 400) begin
            @(posedge clock);
            #10 n++;
        end
        `CHK(req_ready, 1'b1)
        @(posedge clock);
        #10 req_valid = 0;
        n = 0;
        while (!w && rsp_valid !== 1'b1 && n < 40) begin
            @(posedge clock);
            #10 n++;
        end
        if (!w) `CHK(rsp_valid, 1'b1)
        rd = w ? 16'h0000 : rsp_rdata;
        if (w) begin
            @(posedge clock);
            #10;
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        int n;
        do_reset;
        foreach (rows[i]) begin
            do_req(rows[i].w, rows[i].b, rows[i].r, rows[i].c, rows[i].d, rows[i].m);
            if (!rows[i].w) `CHK(rd & keep(rows[i].m), rows[i].e & keep(rows[i].m))
        end
        $display("TB: table test done");
        repeat (400) @(posedge clock);
        #10 `CHK(ref_gap > 9 && ref_gap <= 156, 1'b1)
        `CHK(bank_open, 4'h0)
        $display("TB: refresh test done");
        sleep_req = 1;
        n = 0;
        while (power_down !== 1'b1 && n < 60) begin
            @(posedge clock);
            #10 n++;
        end
        `CHK(power_down, 1'b1)
        `CHK(req_ready, 1'b0)
        sleep_req = 0;
        do_req(1'b0, 2'h1, 12'h002, 12'h00F, 16'h0000, 2'h0);
        `CHK(rd, 16'h1234)
        $display("TB: power-down test done");
        do_reset;
        do_req(1'b0, 2'h2, 12'h003, 12'h000, 16'h0000, 2'h0);
        `CHK(rd, 16'h00FF)
        $display("TB: second reset test done");
        stop_test;
    end

    initial begin
        #(5000 * 100);
        fails++;
        stop_test;
    end
endmodule
